// file: core/lst_line_scan_timing.sv
// Display refresh timing: clock source select, line scan, data latch, drive levels, power enables.
// Assumes control inputs are synchronous to clk_i; only the display clock pin is asynchronous.
module lst_line_scan_timing #(
	parameter int DUTY = lst_pkg::DUTY_DEFAULT,
	parameter int CLKS_PER_LINE = lst_pkg::CLKS_PER_LINE_DEFAULT,
	parameter int OSC_DIV = lst_pkg::OSC_DIV_CYCLES,
	parameter int INT_HOLD = lst_pkg::INT_HOLD_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic display_clock_pin_i,
	input wire logic [lst_pkg::LINE_W-1:0] start_line_i,
	input wire logic com_reverse_i,
	input wire logic display_on_i,
	input wire logic invert_i,
	input wire logic all_on_i,
	input wire logic ram_wr_i,
	input wire logic [lst_pkg::PAGE_W-1:0] ram_page_i,
	input wire logic [lst_pkg::COL_W-1:0] ram_col_i,
	input wire logic [lst_pkg::BITS_PER_PAGE-1:0] ram_data_i,
	input wire logic power_wr_i,
	input wire logic booster_on_i,
	input wire logic regulator_on_i,
	input wire logic follower_on_i,
	output logic [lst_pkg::NUM_COLS-1:0] segment_outputs_o,
	output logic [lst_pkg::NUM_COMS-1:0] common_outputs_o,
	output lst_pkg::lst_level_t [lst_pkg::NUM_COLS-1:0] segment_level_o,
	output lst_pkg::lst_level_t [lst_pkg::NUM_COMS-1:0] common_level_o,
	output logic drive_polarity_signal_o,
	output logic internal_clock_o,
	output logic booster_en_o,
	output logic regulator_en_o,
	output logic follower_en_o
);

	// ****************************************
	// Elaboration checks
	// ****************************************
	if (DUTY < 2 || DUTY > lst_pkg::NUM_COMS) begin : g_chk_duty
		$error("lst_line_scan_timing: DUTY out of range");
	end
	if (CLKS_PER_LINE < 1 || CLKS_PER_LINE >= (1 << lst_pkg::CNT_W)) begin : g_chk_cpl
		$error("lst_line_scan_timing: CLKS_PER_LINE out of range");
	end
	if (OSC_DIV < 1 || OSC_DIV >= (1 << lst_pkg::CNT_W)) begin : g_chk_osc
		$error("lst_line_scan_timing: OSC_DIV out of range");
	end
	if (INT_HOLD < 1 || INT_HOLD >= (1 << lst_pkg::CNT_W)) begin : g_chk_hold
		$error("lst_line_scan_timing: INT_HOLD out of range");
	end

	localparam logic [lst_pkg::CNT_W-1:0] LINE_LAST = lst_pkg::CNT_W'(CLKS_PER_LINE - 1);
	localparam logic [lst_pkg::CNT_W-1:0] OSC_LAST = lst_pkg::CNT_W'(OSC_DIV - 1);
	localparam logic [lst_pkg::CNT_W-1:0] HOLD_COUNT = lst_pkg::CNT_W'(INT_HOLD);
	localparam logic [lst_pkg::LINE_W-1:0] DUTY_LAST = lst_pkg::LINE_W'(DUTY - 1);
	localparam logic [lst_pkg::LINE_W-1:0] COM_LAST = lst_pkg::LINE_W'(lst_pkg::NUM_COMS - 1);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic pin_meta;
		logic pin_sync;
		logic pin_prev;
		logic [lst_pkg::CNT_W-1:0] hi_cnt;
		logic int_mode;
		logic [lst_pkg::CNT_W-1:0] osc_cnt;
		logic [lst_pkg::CNT_W-1:0] tick_cnt;
		logic [lst_pkg::LINE_W-1:0] com_idx;
		logic [lst_pkg::LINE_W-1:0] line_addr;
		logic fr;
		logic [lst_pkg::NUM_COLS-1:0] seg;
		logic [lst_pkg::NUM_COMS-1:0] com;
		lst_pkg::lst_level_t [lst_pkg::NUM_COLS-1:0] seg_lvl;
		lst_pkg::lst_level_t [lst_pkg::NUM_COMS-1:0] com_lvl;
		logic booster;
		logic regulator;
		logic follower;
	} lst_state_t;

	lst_state_t s;
	lst_state_t next_s;
	logic [lst_pkg::NUM_COLS-1:0] ram_row;

	// ****************************************
	// Display RAM
	// ****************************************
	lst_ram #(
		.NUM_COLS(lst_pkg::NUM_COLS),
		.NUM_ROWS(lst_pkg::NUM_ROWS)
	) u_ram (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.wr_i(ram_wr_i),
		.wr_page_i(ram_page_i),
		.wr_col_i(ram_col_i),
		.wr_data_i(ram_data_i),
		.rd_row_i({1'b0, s.line_addr}),
		.rd_data_o(ram_row)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic tick;
		logic [lst_pkg::LINE_W-1:0] com_pos;
		logic [lst_pkg::NUM_COLS-1:0] pix;
		tick = 1'b0;
		com_pos = '0;
		pix = '0;
		next_s = s;

		// Only the second and third stages are read; the first may be metastable
		next_s.pin_meta = display_clock_pin_i;
		next_s.pin_sync = s.pin_meta;
		next_s.pin_prev = s.pin_sync;

		// A level held high longer than any external half period means internal oscillator
		if (!s.pin_sync) begin
			next_s.hi_cnt = '0;
		end else if (s.hi_cnt != HOLD_COUNT) begin
			next_s.hi_cnt = s.hi_cnt + 1'b1;
		end
		next_s.int_mode = s.pin_sync && (s.hi_cnt == HOLD_COUNT);

		if (s.int_mode) begin
			if (s.osc_cnt == OSC_LAST) begin
				next_s.osc_cnt = '0;
				tick = 1'b1;
			end else begin
				next_s.osc_cnt = s.osc_cnt + 1'b1;
			end
		end else begin
			next_s.osc_cnt = '0;
			// A stopped external clock sits low, so no spurious edge appears
			tick = s.pin_sync && !s.pin_prev;
		end

		// ****************************************
		// Line step
		// ****************************************
		if (tick) begin
			if (s.tick_cnt == LINE_LAST) begin
				next_s.tick_cnt = '0;
				// Modifiers act on the copy only; RAM is never written here
				if (!display_on_i) begin
					pix = '0;
				end else if (all_on_i) begin
					pix = '1;
				end else begin
					pix = ram_row ^ {lst_pkg::NUM_COLS{invert_i}};
				end
				next_s.seg = pix;
				com_pos = com_reverse_i ? (COM_LAST - s.com_idx) : s.com_idx;
				next_s.com = '0;
				next_s.com[com_pos] = 1'b1;
				if (s.com_idx == '0) begin
					next_s.fr = ~s.fr;
				end
				if (s.com_idx == DUTY_LAST) begin
					next_s.com_idx = '0;
					next_s.line_addr = start_line_i;
				end else begin
					next_s.com_idx = s.com_idx + 1'b1;
					// Six-bit counter wraps from the top line to line zero by itself
					next_s.line_addr = s.line_addr + 1'b1;
				end
			end else begin
				next_s.tick_cnt = s.tick_cnt + 1'b1;
			end
		end

		// ****************************************
		// Drive levels
		// ****************************************
		for (int i = 0; i < lst_pkg::NUM_COLS; i++) begin
			next_s.seg_lvl[i] = lst_pkg::lst_drive_level(next_s.seg[i], next_s.fr, 1'b0);
		end
		for (int j = 0; j < lst_pkg::NUM_COMS; j++) begin
			next_s.com_lvl[j] = lst_pkg::lst_drive_level(next_s.com[j], next_s.fr, 1'b1);
		end

		// ****************************************
		// Power enables
		// ****************************************
		// Any combination is stored; legal sets are the host's concern
		if (power_wr_i) begin
			next_s.booster = booster_on_i;
			next_s.regulator = regulator_on_i;
			next_s.follower = follower_on_i;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.line_addr <= lst_pkg::RST_LINE;
			s.fr <= lst_pkg::RST_POLARITY;
			s.booster <= lst_pkg::RST_POWER;
			s.regulator <= lst_pkg::RST_POWER;
			s.follower <= lst_pkg::RST_POWER;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign segment_outputs_o = s.seg;
	assign common_outputs_o = s.com;
	assign segment_level_o = s.seg_lvl;
	assign common_level_o = s.com_lvl;
	assign drive_polarity_signal_o = s.fr;
	assign internal_clock_o = s.int_mode;
	assign booster_en_o = s.booster;
	assign regulator_en_o = s.regulator;
	assign follower_en_o = s.follower;

endmodule : lst_line_scan_timing

// file: core/lst_pkg.sv
// Constants, level codes and the drive-level decode for the line scan timing block.
// Assumes a single 20 MHz clock domain and no external package dependencies.
package lst_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int NUM_COLS = 132;
	localparam int NUM_ROWS = 65;
	localparam int NUM_COMS = 64;
	localparam int LINE_W = 6;
	localparam int ROW_W = 7;
	localparam int COL_W = 8;
	localparam int PAGE_W = 4;
	localparam int BITS_PER_PAGE = 8;
	localparam logic [LINE_W-1:0] LAST_LINE = 6'h3f;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int OSC_PERIOD_NS = 400;
	localparam int OSC_DIV_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INT_HOLD_NS = 1000;
	localparam int INT_HOLD_CYCLES = (INT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DUTY_DEFAULT = 64;
	localparam int CLKS_PER_LINE_DEFAULT = 4;
	localparam int CNT_W = 16;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [LINE_W-1:0] RST_LINE = 6'h00;
	localparam logic RST_POLARITY = 1'b0;
	localparam logic RST_POWER = 1'b0;

	// ****************************************
	// Drive levels
	// ****************************************
	typedef enum logic [1:0] {
		LVL_HI_SEL,
		LVL_HI_NSEL,
		LVL_LO_NSEL,
		LVL_LO_SEL
	} lst_level_t;

	// Select polarity follows the frame signal so the panel sees no DC
	function automatic lst_level_t lst_drive_level(input logic sel, input logic fr, input logic is_com);
		lst_level_t lvl;
		if (is_com) begin
			lvl = fr ? (sel ? LVL_HI_SEL : LVL_LO_NSEL) : (sel ? LVL_LO_SEL : LVL_HI_NSEL);
		end else begin
			lvl = fr ? (sel ? LVL_LO_SEL : LVL_HI_NSEL) : (sel ? LVL_HI_SEL : LVL_LO_NSEL);
		end
		return lvl;
	endfunction : lst_drive_level

endpackage : lst_pkg

// file: core/lst_ram.sv
// Display RAM of 65 rows by 132 columns with a byte write port and a row read port.
// Assumes both ports run on the module clock; the row port is combinational.
module lst_ram #(
	parameter int NUM_COLS = lst_pkg::NUM_COLS,
	parameter int NUM_ROWS = lst_pkg::NUM_ROWS
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic wr_i,
	input wire logic [lst_pkg::PAGE_W-1:0] wr_page_i,
	input wire logic [lst_pkg::COL_W-1:0] wr_col_i,
	input wire logic [lst_pkg::BITS_PER_PAGE-1:0] wr_data_i,
	input wire logic [lst_pkg::ROW_W-1:0] rd_row_i,
	output logic [NUM_COLS-1:0] rd_data_o
);

	// ****************************************
	// Checks
	// ****************************************
	if (NUM_COLS < 1 || NUM_COLS > 256 || NUM_ROWS < 1 || NUM_ROWS > 128) begin : g_chk
		$error("lst_ram: unsupported geometry");
	end

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [NUM_ROWS-1:0][NUM_COLS-1:0] rows;
	} lst_ram_state_t;

	lst_ram_state_t s;
	lst_ram_state_t next_s;

	// Page 8 holds one row only, so higher bits of it fall off the end
	always_comb begin
		int row;
		row = 0;
		next_s = s;
		if (wr_i && (32'(wr_col_i) < NUM_COLS)) begin
			for (int b = 0; b < lst_pkg::BITS_PER_PAGE; b++) begin
				row = 32'(wr_page_i) * lst_pkg::BITS_PER_PAGE + b;
				if (row < NUM_ROWS) begin
					next_s.rows[row][wr_col_i] = wr_data_i[b];
				end
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else if (ce_i) begin
			s <= next_s;
		end
	end

	// Separate read port keeps refresh off the write path
	assign rd_data_o = (32'(rd_row_i) < NUM_ROWS) ? s.rows[rd_row_i] : '0;

endmodule : lst_ram

// file: sim/lst_far_side_model.sv
// External display clock source: stopped, running, or held high for the internal oscillator.
// Assumes the bench clock; pin changes just after the rising edge.
module lst_far_side_model (
	input wire logic clk_i,
	input wire logic [1:0] mode_i,
	output logic pin_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] cnt = 2'h0;
	initial pin_o = 1'b0;
	// High phase of 3 cycles stays under the internal-mode hold time
	always @(posedge clk_i) begin
		cnt <= (cnt == 2'h2) ? 2'h0 : cnt + 2'h1;
		if (mode_i == 2'h0) pin_o <= 1'b0;
		else if (mode_i == 2'h2) pin_o <= 1'b1;
		else if (cnt == 2'h2) pin_o <= !pin_o;
	end
endmodule : lst_far_side_model

// file: sim/lst_scan_properties.sv
// Checker for the line scan timing block: scan order, polarity, latch modifiers, levels, power enables.
// Assumes one clock domain and sees only the top module's ports; bound below.
module lst_scan_checker #(
	parameter int DUTY = 64
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic com_reverse_i,
	input wire logic display_on_i,
	input wire logic all_on_i,
	input wire logic power_wr_i,
	input wire logic booster_on_i,
	input wire logic regulator_on_i,
	input wire logic follower_on_i,
	input wire logic [lst_pkg::NUM_COLS-1:0] segment_outputs_o,
	input wire logic [lst_pkg::NUM_COMS-1:0] common_outputs_o,
	input wire lst_pkg::lst_level_t [lst_pkg::NUM_COLS-1:0] segment_level_o,
	input wire lst_pkg::lst_level_t [lst_pkg::NUM_COMS-1:0] common_level_o,
	input wire logic drive_polarity_signal_o,
	input wire logic booster_en_o,
	input wire logic regulator_en_o,
	input wire logic follower_en_o
);
	// ****
	// Properties
	// ****
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_line;
		$changed(common_outputs_o);
	endsequence
	sequence s_lit;
		s_line ##0 $past(display_on_i);
	endsequence
	a_com_onehot: assert property ($onehot0(common_outputs_o)) else $error("common not one-hot");
	a_com_next: assert property ((s_line ##0 ($past(common_outputs_o[0]) && !$past(com_reverse_i) && DUTY > 1))
		|-> common_outputs_o[1]) else $error("common step wrong");
	a_fr_toggle: assert property ((s_line ##0 (common_outputs_o[0] && !$past(com_reverse_i)))
		|-> $changed(drive_polarity_signal_o)) else $error("polarity missed frame");
	a_fr_steady: assert property ($changed(drive_polarity_signal_o) |-> s_line) else $error("polarity moved");
	a_disp_off: assert property ((s_line ##0 !$past(display_on_i)) |-> segment_outputs_o == '0)
		else $error("display off not blank");
	a_all_on: assert property ((s_lit ##0 $past(all_on_i)) |-> &segment_outputs_o) else $error("all on failed");
	a_pwr_load: assert property (ce_i && power_wr_i |=> booster_en_o == $past(booster_on_i)
		&& regulator_en_o == $past(regulator_on_i) && follower_en_o == $past(follower_on_i)) else $error("power load");
	a_pwr_hold: assert property (!$past(power_wr_i) |-> $stable(booster_en_o) && $stable(regulator_en_o)
		&& $stable(follower_en_o)) else $error("power enable moved");
	a_com_level: assert property (common_outputs_o[0] |-> common_level_o[0] ==
		(drive_polarity_signal_o ? lst_pkg::LVL_HI_SEL : lst_pkg::LVL_LO_SEL)) else $error("common level");
	a_seg_level: assert property (|common_outputs_o |-> segment_level_o[0] == (drive_polarity_signal_o ?
		(segment_outputs_o[0] ? lst_pkg::LVL_LO_SEL : lst_pkg::LVL_HI_NSEL) :
		(segment_outputs_o[0] ? lst_pkg::LVL_HI_SEL : lst_pkg::LVL_LO_NSEL))) else $error("segment level");
endmodule : lst_scan_checker

bind lst_line_scan_timing lst_scan_checker #(.DUTY(DUTY)) i_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.com_reverse_i(com_reverse_i), .display_on_i(display_on_i), .all_on_i(all_on_i), .power_wr_i(power_wr_i),
	.booster_on_i(booster_on_i), .regulator_on_i(regulator_on_i), .follower_on_i(follower_on_i),
	.segment_outputs_o(segment_outputs_o), .common_outputs_o(common_outputs_o), .segment_level_o(segment_level_o),
	.common_level_o(common_level_o), .drive_polarity_signal_o(drive_polarity_signal_o),
	.booster_en_o(booster_en_o), .regulator_en_o(regulator_en_o), .follower_en_o(follower_en_o));

// file: sim/testbench.sv
// Self-checking bench for the line scan timing block with a small duty and fast display clock.
// Assumes the checker is bound to the design and the far side model drives the clock pin.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DUTY = 4;
	logic clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, pin, rev = 1'b0, on = 1'b1, inv = 1'b0, all = 1'b0;
	logic ram_wr_i = 1'b0, power_wr_i = 1'b0, mon = 1'b0, fr, last_fr = 1'b0, intc, be, re, fe;
	logic q_rev, q_on, q_inv, q_all;
	logic [5:0] start_line = 6'h00, exp_line = 6'h00, q_start;
	logic [3:0] page = 4'h0;
	logic [7:0] col = 8'h00, data = 8'h00;
	logic [2:0] pwr = 3'h0, want;
	logic [1:0] mode = 2'h1;
	logic [131:0] seg, img [64];
	logic [63:0] com, last_com = 64'h0, held;
	int n_fail = 0, checks = 0, k, exp_k = 0;
	always #25 clk_i = ~clk_i;
	lst_far_side_model i_far (.clk_i(clk_i), .mode_i(mode), .pin_o(pin));
	lst_line_scan_timing #(.DUTY(DUTY), .CLKS_PER_LINE(1), .OSC_DIV(1), .INT_HOLD(4)) i_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .display_clock_pin_i(pin), .start_line_i(start_line),
		.com_reverse_i(rev), .display_on_i(on), .invert_i(inv), .all_on_i(all), .ram_wr_i(ram_wr_i),
		.ram_page_i(page), .ram_col_i(col), .ram_data_i(data), .power_wr_i(power_wr_i), .booster_on_i(pwr[2]),
		.regulator_on_i(pwr[1]), .follower_on_i(pwr[0]), .segment_outputs_o(seg), .common_outputs_o(com),
		.segment_level_o(), .common_level_o(), .drive_polarity_signal_o(fr), .internal_clock_o(intc),
		.booster_en_o(be), .regulator_en_o(re), .follower_en_o(fe));
	// ****
	// Helpers
	// ****
	task automatic chk(input logic [131:0] seen, input logic [131:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [131:0] exp_seg(input logic [131:0] r, input logic o, input logic i, input logic a);
		return !o ? '0 : a ? '1 : i ? ~r : r;
	endfunction : exp_seg
	// Image is updated after the taken edge so a latch on that edge still sees old data
	task automatic wr(input logic [3:0] p, input logic [7:0] c, input logic [7:0] d);
		@(posedge clk_i);
		ram_wr_i <= 1'b1;
		page <= p;
		col <= c;
		data <= d;
		@(posedge clk_i);
		ram_wr_i <= 1'b0;
		@(negedge clk_i);
		#1;
		for (int b = 0; b < 8; b++) if (p < 8 && c < 132) img[p * 8 + b][c] = d[b];
	endtask : wr
	task automatic wrap_up;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : wrap_up
	// Config in force at a latch edge is the value seen at the negedge before it
	always @(negedge clk_i) begin
		if (com !== last_com) begin
			k = 0;
			for (int i = 0; i < 64; i++) if (com[i]) k = q_rev ? 63 - i : i;
			chk(k, exp_k);
			if (mon) chk(seg, exp_seg(img[exp_line], q_on, q_inv, q_all));
			if (k == 0) chk(fr, !last_fr);
			else chk(fr, last_fr);
			exp_line = (k == DUTY - 1) ? q_start : exp_line + 6'h01;
			exp_k = (exp_k + 1) % DUTY;
			last_com = com;
			last_fr = fr;
		end
		{q_start, q_rev, q_on, q_inv, q_all} = {start_line, rev, on, inv, all};
	end
	// ****
	// Tests
	// ****
	initial begin
		void'($urandom(32'h0a3e));
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// Host keeps to the legal supply sets: all on, regulator plus follower, follower, all off
		for (int i = 0; i < 4; i++) begin
			want = (i == 0) ? 3'h7 : (i == 1) ? 3'h3 : (i == 2) ? 3'h1 : 3'h0;
			@(posedge clk_i);
			power_wr_i <= 1'b1;
			pwr <= want;
			@(posedge clk_i);
			power_wr_i <= 1'b0;
			@(negedge clk_i);
			chk({be, re, fe}, want);
		end
		for (int p = 0; p < 9; p++) for (int c = 0; c < 133; c++) wr(p[3:0], c[7:0], 8'($urandom));
		wr(4'h9, 8'h05, 8'hff);
		mon = 1'b1;
		for (int n = 0; n < 16; n++) begin
			@(posedge clk_i);
			start_line <= (n == 0) ? 6'h3f : 6'($urandom);
			rev <= n[0];
			on <= (n < 4) || 1'($urandom);
			inv <= n[1];
			all <= n[2] & n[3];
			repeat (20) wr(4'($urandom % 8), 8'($urandom % 132), 8'($urandom));
		end
		mode <= 2'h2;
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		chk(intc, 1'b1);
		repeat (40) @(posedge clk_i);
		mode <= 2'h1;
		repeat (30) @(posedge clk_i);
		@(negedge clk_i);
		chk(intc, 1'b0);
		// Clock enable low must freeze the scan
		@(posedge clk_i);
		ce_i <= 1'b0;
		@(negedge clk_i);
		held = com;
		repeat (30) @(posedge clk_i);
		@(negedge clk_i);
		chk(com, held);
		@(posedge clk_i);
		ce_i <= 1'b1;
		mode <= 2'h0;
		repeat (10) @(posedge clk_i);
		@(negedge clk_i);
		held = com;
		repeat (40) @(posedge clk_i);
		@(negedge clk_i);
		chk(com, held);
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		wrap_up();
	end
endmodule : testbench
